// *** logic/cmp_ctrl.sv ***
// comparator control: register port, pin mode switching, result readback
`timescale 1ns/1ns
// What this block does
// - comparison runs only in active or subactive mode, halted otherwise.
// - select bits 00 choose first input, 01 second, 1x unused.
// - run bit 3 set makes both shared pins analog and starts comparison.
// - while running neither shared pin serves as a general port pin.
// - enable register is write-only, with run and two select bits.
// - reset or stop mode clears the enable register.
// - result register is read-only with bits 0 and 1.
// - while sampling, the selected pin outcome loads its result bit every cycle.
// - result is not retained after comparison stops.
module cmp_ctrl (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic [1:0] CPU_MODE,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [9:0] REG_ADDR,
  input wire logic [3:0] REG_WDATA,
  output logic [3:0] REG_RDATA,
  input wire logic CMP_OUT_FIRST,
  input wire logic CMP_OUT_SECOND,
  output logic CMP_POWER_EN,
  output logic ANALOG_MODE,
  output logic PORT_EN_FIRST,
  output logic PORT_EN_SECOND
);
  typedef struct packed {
    logic [3:0] rdata_ff;
  } top_state_t;
  top_state_t st_ff;
  top_state_t nxt_st;
  logic [3:0] enable;
  logic [1:0] result;
  logic stop_mode;
  logic mode_ok;
  logic run;
  logic sel_valid;
  logic wr_enable;
  logic result_read;
  logic enable_read;
  logic first_pick;
  logic second_pick;

  function automatic logic addr_hit(input logic [9:0] a, input logic [9:0] ofs);
    addr_hit = (a == ofs);
  endfunction : addr_hit

  assign stop_mode = (CPU_MODE == cmp_ctrl_pkg::MODE_STOP);
  assign mode_ok = (CPU_MODE == cmp_ctrl_pkg::MODE_ACTIVE) ||
                   (CPU_MODE == cmp_ctrl_pkg::MODE_SUBACTIVE);
  assign wr_enable = REG_WR && addr_hit(REG_ADDR, cmp_ctrl_pkg::OFS_ENABLE);
  // select value 1x is unused: no pin is compared then
  assign sel_valid = !enable[cmp_ctrl_pkg::SEL_HI_POS];
  assign run = enable[cmp_ctrl_pkg::RUN_POS] && mode_ok;
  // decodes shared by the checks at the end of the module
  assign result_read = REG_RD && addr_hit(REG_ADDR, cmp_ctrl_pkg::OFS_RESULT);
  assign enable_read = REG_RD && addr_hit(REG_ADDR, cmp_ctrl_pkg::OFS_ENABLE);
  assign first_pick = run && sel_valid && !enable[cmp_ctrl_pkg::SEL_LO_POS];
  assign second_pick = run && sel_valid && enable[cmp_ctrl_pkg::SEL_LO_POS];

  cmp_enable_reg u_enable (
    .CLK(CLK),
    .NRST(NRST),
    .stop_mode(stop_mode),
    .wr(wr_enable),
    .wdata(REG_WDATA),
    .enable(enable)
  );

  cmp_result_reg u_result (
    .CLK(CLK),
    .NRST(NRST),
    .sample(run && sel_valid),
    .sel(enable[cmp_ctrl_pkg::SEL_LO_POS]),
    .cmp_first(CMP_OUT_FIRST),
    .cmp_second(CMP_OUT_SECOND),
    .result(result)
  );

  always_comb begin
    nxt_st = st_ff;
    nxt_st.rdata_ff = 4'h0;
    // enable register is write-only, so only the result address answers
    if (REG_RD && addr_hit(REG_ADDR, cmp_ctrl_pkg::OFS_RESULT)) begin
      nxt_st.rdata_ff = {2'h0, result};
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      st_ff <= '{rdata_ff: 4'h0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign REG_RDATA = st_ff.rdata_ff;
  assign CMP_POWER_EN = run;
  // pin mode follows the run bit alone so the port stays off even if halted
  assign ANALOG_MODE = enable[cmp_ctrl_pkg::RUN_POS];
  assign PORT_EN_FIRST = !enable[cmp_ctrl_pkg::RUN_POS];
  assign PORT_EN_SECOND = !enable[cmp_ctrl_pkg::RUN_POS];

  // all checks share the one clock, and all but the reset check are disabled
  // by the synchronous reset; checks with several steps are built from the named sequences that follow

  // a write that sets the run bit and is not overridden by stop mode
  sequence seq_run_write;
    wr_enable && REG_WDATA[cmp_ctrl_pkg::RUN_POS] && !stop_mode;
  endsequence : seq_run_write

  // a write that clears the run bit
  sequence seq_idle_write;
    wr_enable && !REG_WDATA[cmp_ctrl_pkg::RUN_POS];
  endsequence : seq_idle_write

  // writes that choose the first, the second and the unused select code
  sequence seq_pick_first_write;
    wr_enable && !stop_mode && REG_WDATA[cmp_ctrl_pkg::RUN_POS] &&
      REG_WDATA[cmp_ctrl_pkg::SEL_HI_POS:cmp_ctrl_pkg::SEL_LO_POS] == 2'h0;
  endsequence : seq_pick_first_write

  sequence seq_pick_second_write;
    wr_enable && !stop_mode && REG_WDATA[cmp_ctrl_pkg::RUN_POS] &&
      REG_WDATA[cmp_ctrl_pkg::SEL_HI_POS:cmp_ctrl_pkg::SEL_LO_POS] == 2'h1;
  endsequence : seq_pick_second_write

  sequence seq_unused_write;
    wr_enable && !stop_mode && REG_WDATA[cmp_ctrl_pkg::SEL_HI_POS];
  endsequence : seq_unused_write

  // two idle cycles leave nothing in the result register
  sequence seq_idle_then_read;
    !ANALOG_MODE ##1 !ANALOG_MODE ##1 result_read;
  endsequence : seq_idle_then_read

  // a halted cycle drains it as well, since sampling needs a running mode
  sequence seq_halt_then_read;
    !mode_ok ##1 result_read;
  endsequence : seq_halt_then_read

  // an unused select code stops sampling and drains the result
  sequence seq_unused_then_read;
    !sel_valid ##1 result_read;
  endsequence : seq_unused_then_read

  // a sampling cycle on one input, then a read of the result
  sequence seq_first_then_read;
    first_pick ##1 result_read;
  endsequence : seq_first_then_read

  sequence seq_second_then_read;
    second_pick ##1 result_read;
  endsequence : seq_second_then_read

  property p_halt_outside_modes;
    @(posedge CLK) disable iff (!NRST)
    !mode_ok |-> !CMP_POWER_EN;
  endproperty : p_halt_outside_modes
  AST_HALT_OUTSIDE_MODES: assert property (p_halt_outside_modes)
    else $error("comparator on in wrong mode");

  property p_power_in_mode;
    @(posedge CLK) disable iff (!NRST)
    mode_ok && ANALOG_MODE |-> CMP_POWER_EN;
  endproperty : p_power_in_mode
  AST_POWER_IN_MODE: assert property (p_power_in_mode)
    else $error("comparator off in running mode");

  property p_halt_clears;
    @(posedge CLK) disable iff (!NRST)
    seq_halt_then_read |=> REG_RDATA == 4'h0;
  endproperty : p_halt_clears
  AST_HALT_CLEARS: assert property (p_halt_clears)
    else $error("result kept while halted");

  property p_pick_first;
    @(posedge CLK) disable iff (!NRST)
    seq_pick_first_write ##1 mode_ok |-> first_pick;
  endproperty : p_pick_first
  AST_PICK_FIRST: assert property (p_pick_first)
    else $error("first input not selected");

  property p_pick_second;
    @(posedge CLK) disable iff (!NRST)
    seq_pick_second_write ##1 mode_ok |-> second_pick;
  endproperty : p_pick_second
  AST_PICK_SECOND: assert property (p_pick_second)
    else $error("second input not selected");

  property p_pick_unused;
    @(posedge CLK) disable iff (!NRST)
    seq_unused_write |=> !sel_valid;
  endproperty : p_pick_unused
  AST_PICK_UNUSED: assert property (p_pick_unused)
    else $error("unused select code samples a pin");

  property p_unused_clears;
    @(posedge CLK) disable iff (!NRST)
    seq_unused_then_read |=> REG_RDATA == 4'h0;
  endproperty : p_unused_clears
  AST_UNUSED_CLEARS: assert property (p_unused_clears)
    else $error("result kept with unused select");

  property p_start_analog;
    @(posedge CLK) disable iff (!NRST)
    seq_run_write |=> ANALOG_MODE && !PORT_EN_FIRST && !PORT_EN_SECOND;
  endproperty : p_start_analog
  AST_START_ANALOG: assert property (p_start_analog)
    else $error("run write did not switch pins");

  property p_power_needs_run;
    @(posedge CLK) disable iff (!NRST)
    CMP_POWER_EN |-> ANALOG_MODE;
  endproperty : p_power_needs_run
  AST_POWER_NEEDS_RUN: assert property (p_power_needs_run)
    else $error("comparator on without run bit");

  property p_stop_returns_port;
    @(posedge CLK) disable iff (!NRST)
    seq_idle_write |=> PORT_EN_FIRST && PORT_EN_SECOND;
  endproperty : p_stop_returns_port
  AST_STOP_RETURNS_PORT: assert property (p_stop_returns_port)
    else $error("pins not returned to port");

  property p_idle_ports;
    @(posedge CLK) disable iff (!NRST)
    !ANALOG_MODE |-> PORT_EN_FIRST && PORT_EN_SECOND;
  endproperty : p_idle_ports
  AST_IDLE_PORTS: assert property (p_idle_ports)
    else $error("port pin off while idle");

  property p_both_pins_off;
    @(posedge CLK) disable iff (!NRST)
    ANALOG_MODE |-> !PORT_EN_FIRST && !PORT_EN_SECOND;
  endproperty : p_both_pins_off
  AST_BOTH_PINS_OFF: assert property (p_both_pins_off)
    else $error("port pin active while running");

  property p_enable_holds;
    @(posedge CLK) disable iff (!NRST)
    !wr_enable && !stop_mode |=> $stable(ANALOG_MODE);
  endproperty : p_enable_holds
  AST_ENABLE_HOLDS: assert property (p_enable_holds)
    else $error("run bit changed without a write");

  property p_enable_unreadable;
    @(posedge CLK) disable iff (!NRST)
    enable_read |=> REG_RDATA == 4'h0;
  endproperty : p_enable_unreadable
  AST_ENABLE_UNREADABLE: assert property (p_enable_unreadable)
    else $error("enable register answered a read");

  property p_reset_idle;
    @(posedge CLK)
    !NRST |=> !ANALOG_MODE && PORT_EN_FIRST && PORT_EN_SECOND && REG_RDATA == 4'h0;
  endproperty : p_reset_idle
  AST_RESET_IDLE: assert property (p_reset_idle)
    else $error("reset did not idle the block");

  property p_stop_drops_pins;
    @(posedge CLK) disable iff (!NRST)
    stop_mode |=> !ANALOG_MODE && PORT_EN_FIRST && PORT_EN_SECOND;
  endproperty : p_stop_drops_pins
  AST_STOP_DROPS_PINS: assert property (p_stop_drops_pins)
    else $error("stop mode kept comparison on");

  property p_read_matches;
    @(posedge CLK) disable iff (!NRST)
    result_read |=> REG_RDATA[1:0] == $past(result);
  endproperty : p_read_matches
  AST_READ_MATCHES: assert property (p_read_matches)
    else $error("read data wrong");

  property p_no_read_zero;
    @(posedge CLK) disable iff (!NRST)
    !result_read |=> REG_RDATA == 4'h0;
  endproperty : p_no_read_zero
  AST_NO_READ_ZERO: assert property (p_no_read_zero)
    else $error("read data without a result read");

  property p_first_readback;
    @(posedge CLK) disable iff (!NRST)
    seq_first_then_read |=> REG_RDATA[cmp_ctrl_pkg::RES_FIRST_POS] == $past(CMP_OUT_FIRST, 2);
  endproperty : p_first_readback
  AST_FIRST_READBACK: assert property (p_first_readback)
    else $error("first outcome not read back");

  property p_second_readback;
    @(posedge CLK) disable iff (!NRST)
    seq_second_then_read |=> REG_RDATA[cmp_ctrl_pkg::RES_SECOND_POS] == $past(CMP_OUT_SECOND, 2);
  endproperty : p_second_readback
  AST_SECOND_READBACK: assert property (p_second_readback)
    else $error("second outcome not read back");

  property p_cleared_after_stop;
    @(posedge CLK) disable iff (!NRST)
    seq_idle_then_read |=> REG_RDATA == 4'h0;
  endproperty : p_cleared_after_stop
  AST_CLEARED_AFTER_STOP: assert property (p_cleared_after_stop)
    else $error("result kept after stop");

  property p_upper_zero;
    @(posedge CLK) disable iff (!NRST)
    REG_RDATA[3:2] == 2'h0;
  endproperty : p_upper_zero
  AST_UPPER_ZERO: assert property (p_upper_zero)
    else $error("upper result bits nonzero");
endmodule : cmp_ctrl

// *** logic/cmp_ctrl_pkg.sv ***
// shared constants for the two-input comparator control block
package cmp_ctrl_pkg;
  localparam logic [9:0] OFS_RESULT = 10'h017;
  localparam logic [9:0] OFS_ENABLE = 10'h018;
  localparam int SEL_LO_POS = 0;
  localparam int SEL_HI_POS = 1;
  localparam int RUN_POS = 3;
  localparam int RES_FIRST_POS = 0;
  localparam int RES_SECOND_POS = 1;
  localparam logic [3:0] ENABLE_RST = 4'h0;
  localparam logic [3:0] ENABLE_MASK = 4'hb;
  localparam logic [1:0] RESULT_RST = 2'h0;
  typedef enum logic [1:0] {
    MODE_ACTIVE = 2'h0,
    MODE_SUBACTIVE = 2'h1,
    MODE_STOP = 2'h3,
    MODE_OTHER = 2'h2
  } cpu_mode_t;
endpackage : cmp_ctrl_pkg

// *** logic/cmp_enable_reg.sv ***
// write-only enable register: run bit and input select
`timescale 1ns/1ns
module cmp_enable_reg (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic stop_mode,
  input wire logic wr,
  input wire logic [3:0] wdata,
  output logic [3:0] enable
);
  typedef struct packed {
    logic [3:0] enable_ff;
  } en_state_t;
  en_state_t st_ff;
  en_state_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (stop_mode) begin
      nxt_st.enable_ff = cmp_ctrl_pkg::ENABLE_RST;
    end else if (wr) begin
      nxt_st.enable_ff = wdata & cmp_ctrl_pkg::ENABLE_MASK;
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      st_ff <= '{enable_ff: cmp_ctrl_pkg::ENABLE_RST};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign enable = st_ff.enable_ff;

  AST_STOP_CLEARS: assert property (@(posedge CLK) disable iff (!NRST)
    stop_mode |=> enable == 4'h0) else $error("stop did not clear enable");
  AST_BIT2_ZERO: assert property (@(posedge CLK) disable iff (!NRST)
    enable[2] == 1'b0) else $error("unused enable bit set");
endmodule : cmp_enable_reg

// *** logic/cmp_result_reg.sv ***
// result register: samples the selected comparator outcome
`timescale 1ns/1ns
module cmp_result_reg (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic sample,
  input wire logic sel,
  input wire logic cmp_first,
  input wire logic cmp_second,
  output logic [1:0] result
);
  typedef struct packed {
    logic [1:0] result_ff;
  } res_state_t;
  res_state_t st_ff;
  res_state_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (!sample) begin
      // contents are not kept once comparison stops
      nxt_st.result_ff = cmp_ctrl_pkg::RESULT_RST;
    end else if (sel) begin
      nxt_st.result_ff[cmp_ctrl_pkg::RES_SECOND_POS] = cmp_second;
    end else begin
      nxt_st.result_ff[cmp_ctrl_pkg::RES_FIRST_POS] = cmp_first;
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      st_ff <= '{result_ff: cmp_ctrl_pkg::RESULT_RST};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign result = st_ff.result_ff;

  AST_FIRST_TRACKS: assert property (@(posedge CLK) disable iff (!NRST)
    sample && !sel |=> result[0] == $past(cmp_first)) else $error("first result not loaded");
  AST_SECOND_TRACKS: assert property (@(posedge CLK) disable iff (!NRST)
    sample && sel |=> result[1] == $past(cmp_second)) else $error("second result not loaded");
endmodule : cmp_result_reg

// *** tb/cmp_ctrl_tb.sv ***
// self-checking bench for the comparator control block
`timescale 1ns/1ns
module cmp_ctrl_tb;
  logic CLK = 1'b0;
  logic NRST = 1'b0;
  logic [1:0] CPU_MODE = 2'h0;
  logic REG_WR = 1'b0;
  logic REG_RD = 1'b0;
  logic [9:0] REG_ADDR = 10'h000;
  logic [3:0] REG_WDATA = 4'h0;
  logic [3:0] REG_RDATA;
  logic CMP_OUT_FIRST = 1'b0;
  logic CMP_OUT_SECOND = 1'b0;
  logic CMP_POWER_EN, ANALOG_MODE, PORT_EN_FIRST, PORT_EN_SECOND;
  logic [3:0] rd;
  int mismatches = 0;
  int samples_checked = 0;
  always #5 CLK = ~CLK;
  cmp_ctrl dut (.CLK(CLK), .NRST(NRST), .CPU_MODE(CPU_MODE), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .CMP_OUT_FIRST(CMP_OUT_FIRST),
    .CMP_OUT_SECOND(CMP_OUT_SECOND), .CMP_POWER_EN(CMP_POWER_EN), .ANALOG_MODE(ANALOG_MODE),
    .PORT_EN_FIRST(PORT_EN_FIRST), .PORT_EN_SECOND(PORT_EN_SECOND));
  task automatic test_done;
    if (mismatches == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // pin view packed as power, analog, port second, port first
  task automatic chk_pins(input logic [3:0] exp);
    #1 chk({CMP_POWER_EN, ANALOG_MODE, PORT_EN_SECOND, PORT_EN_FIRST}, exp);
  endtask : chk_pins
  task automatic wr_reg(input logic [9:0] a, input logic [3:0] d);
    @(negedge CLK);
    REG_WR = 1'b1; REG_ADDR = a; REG_WDATA = d;
    @(negedge CLK);
    REG_WR = 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [9:0] a, output logic [3:0] d);
    @(negedge CLK);
    REG_RD = 1'b1; REG_ADDR = a;
    @(negedge CLK);
    REG_RD = 1'b0;
    d = REG_RDATA;
  endtask : rd_reg
  task automatic test_reset;
    chk_pins(4'h3);
    rd_reg(cmp_ctrl_pkg::OFS_RESULT, rd); chk(rd, 4'h0);
    rd_reg(cmp_ctrl_pkg::OFS_ENABLE, rd); chk(rd, 4'h0);
    rd_reg(10'h016, rd); chk(rd, 4'h0);
  endtask : test_reset
  task automatic test_first;
    CMP_OUT_FIRST = 1'b1;
    wr_reg(cmp_ctrl_pkg::OFS_ENABLE, 4'hc); // unused bit 2 set as well
    chk_pins(4'hc);
    wr_reg(cmp_ctrl_pkg::OFS_RESULT, 4'h0);
    rd_reg(cmp_ctrl_pkg::OFS_RESULT, rd); chk(rd, 4'h1);
    CMP_OUT_FIRST = 1'b0;
    repeat (2) @(negedge CLK);
    rd_reg(cmp_ctrl_pkg::OFS_RESULT, rd); chk(rd, 4'h0);
  endtask : test_first
  task automatic test_second;
    // first is still low from the earlier run, so the bit it left is known; raising it later must not change it
    CMP_OUT_SECOND = 1'b1;
    wr_reg(cmp_ctrl_pkg::OFS_ENABLE, 4'h9);
    repeat (2) @(negedge CLK);
    rd_reg(cmp_ctrl_pkg::OFS_RESULT, rd); chk(rd, 4'h2);
    CMP_OUT_FIRST = 1'b1;
    repeat (2) @(negedge CLK);
    rd_reg(cmp_ctrl_pkg::OFS_RESULT, rd); chk(rd, 4'h2);
  endtask : test_second
  task automatic test_modes;
    CPU_MODE = 2'h1; chk_pins(4'hc);
    @(negedge CLK); CPU_MODE = 2'h2; chk_pins(4'h4);
    rd_reg(cmp_ctrl_pkg::OFS_RESULT, rd); chk(rd, 4'h0);
    @(negedge CLK); CPU_MODE = 2'h3;
    @(negedge CLK); CPU_MODE = 2'h0; chk_pins(4'h3);
  endtask : test_modes
  task automatic test_stop;
    wr_reg(cmp_ctrl_pkg::OFS_ENABLE, 4'h8);
    wr_reg(cmp_ctrl_pkg::OFS_ENABLE, 4'h0);
    chk_pins(4'h3);
    rd_reg(cmp_ctrl_pkg::OFS_RESULT, rd); chk(rd, 4'h0);
    wr_reg(cmp_ctrl_pkg::OFS_ENABLE, 4'ha);
    chk_pins(4'hc);
    rd_reg(cmp_ctrl_pkg::OFS_RESULT, rd); chk(rd, 4'h0);
  endtask : test_stop
  initial begin
    repeat (12) @(negedge CLK);
    NRST = 1'b1;
    test_reset();
    test_first();
    test_second();
    test_modes();
    test_stop();
    test_done();
  end
  // the whole sequence needs well under 200 cycles
  initial begin
    repeat (2000) @(posedge CLK);
    mismatches++;
    test_done();
  end
endmodule : cmp_ctrl_tb
